// ===== verilog/scpm_pkg.sv
// Package of constants and types for the system clock and power mode controller
package scpm_pkg;

  // ----------------------------------------------------------------------
  // Register offsets, field positions and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] ADDR_MODE      = 2'h0;
  localparam logic [1:0] ADDR_FAST_RC   = 2'h1;
  localparam logic [1:0] ADDR_FAST_XTAL = 2'h2;
  localparam logic [1:0] ADDR_SLOW_XTAL = 2'h3;

  localparam int         SEL_MSB        = 7;
  localparam int         SEL_LSB        = 5;
  localparam int         FAST_SRC_BIT   = 3;
  localparam int         SLOW_SRC_BIT   = 2;
  localparam int         FAST_KEEP_BIT  = 1;
  localparam int         SLOW_KEEP_BIT  = 0;
  localparam int         RC_FREQ_MSB    = 3;
  localparam int         RC_FREQ_LSB    = 2;
  localparam int         XT_MODE_BIT    = 2;
  localparam int         STABLE_BIT     = 1;
  localparam int         ENABLE_BIT     = 0;

  localparam logic [7:0] MODE_RST       = 8'h00;
  localparam logic [7:0] FAST_RC_RST    = 8'h01;
  localparam logic [7:0] FAST_XTAL_RST  = 8'h00;
  localparam logic [7:0] SLOW_XTAL_RST  = 8'h00;

  localparam logic [2:0] SEL_SLOW       = 3'h7;
  localparam logic [1:0] RC_FREQ_12M    = 2'h1;
  localparam logic [1:0] RC_FREQ_16M    = 2'h2;

  // ----------------------------------------------------------------------
  // Timing: oscillator start-up times and their cycle counts at core_clk
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ            = 10000;
  localparam int FAST_RC_START_US   = 16;
  localparam int FAST_XTAL_START_US = 1000;
  localparam int SLOW_XT_FAST_US    = 100000;
  localparam int SLOW_XT_LOWP_US    = 1000000;
  localparam int SLOW_PERIOD_NS     = 30518;
  localparam int FAST_RC_START_CYC  = (FAST_RC_START_US * CLK_KHZ + 999) / 1000;
  localparam int FAST_XTAL_CYC      = (FAST_XTAL_START_US * CLK_KHZ + 999) / 1000;
  localparam int SLOW_XT_FAST_CYC   = (SLOW_XT_FAST_US * (CLK_KHZ / 1000));
  localparam int SLOW_XT_LOWP_CYC   = (SLOW_XT_LOWP_US * (CLK_KHZ / 1000));
  localparam int SLOW_DIV_CYC       = (SLOW_PERIOD_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int CNT_W              = 24;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_SLOW, MODE_SLEEP, MODE_IDLE_SLOW_ONLY,
    MODE_IDLE_BOTH_CLOCKS, MODE_IDLE_FAST_ONLY
  } scpm_mode_type;

  typedef struct packed {
    logic internal_fast_rc;
    logic external_fast_crystal;
    logic internal_slow_rc;
    logic external_slow_crystal;
  } scpm_osc_type;

endpackage

// ===== verilog/scpm_clock_ctrl.sv
// System clock select, oscillator control and operating mode controller
//
// Overview of operation
// RULE1: select codes 0..6 give fast clock divided by 1..64, code 7 slow clock
// RULE2: fast source bit picks internal fast RC (0) or external fast crystal (1)
// RULE3: slow source bit picks internal slow RC (0) or external slow crystal (1)
// RULE4: halt with both keep bits 0 enters sleep; only watchdog slow RC runs
// RULE5: halt with fast keep 0, slow keep 1: slow-only idle, sysclk only if code 7
// RULE6: halt with both keep bits 1: idle with all clocks running
// RULE7: halt with fast keep 1, slow keep 0: fast-only idle, sysclk stops on code 7
// RULE8: normal mode runs CPU from selected fast oscillator divided 1..64
// RULE9: in slow mode the fast oscillator follows its own enable bit
// RULE10: fast keep bit decides whether fast oscillator runs while halted
// RULE11: slow keep bit decides whether slow oscillator runs while halted
// RULE12: internal slow RC stays on while the watchdog is enabled
// RULE13: fast RC frequency codes: 00 and 11 8 MHz, 01 12 MHz, 10 16 MHz
// RULE14: a new fast RC frequency takes effect only once stable is set
// RULE15: enabling fast RC or changing frequency clears stable, later sets it
// RULE16: fast RC enable bit turns oscillator on, resets to 1
// RULE17: unimplemented bits ignore writes and read as zero
// RULE18: enabling fast crystal clears its stable flag, set when stable
// RULE19: enabling slow crystal clears its stable flag, set when stable
// RULE20: switch to slow clock completes only after slow source is stable
// RULE21: clock select changes switch without glitches or runt pulses
`timescale 1ns/1ns
`default_nettype none
module scpm_clock_ctrl
  import scpm_pkg::*;
#(
  parameter int FAST_XTAL_START = FAST_XTAL_CYC,
  parameter int SLOW_XT_FAST    = SLOW_XT_FAST_CYC,
  parameter int SLOW_XT_LOWP    = SLOW_XT_LOWP_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic [1:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  input  wire logic          halt_req,
  input  wire logic          wake_req,
  input  wire logic          wdt_enable,
  output logic               cpu_run,
  output logic               sys_tick,
  output logic               fast_clock_run,
  output logic               slow_clock_run,
  output scpm_osc_type       osc_run,
  output scpm_mode_type      op_mode,
  output logic      [1:0]    fast_rc_freq_active,
  output logic      [4:0]    fast_rc_mhz
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Stability counter step: restarts on stop or restart request
  function automatic logic [CNT_W-1:0] next_count(input logic run, input logic restart,
                                                  input logic [CNT_W-1:0] cnt,
                                                  input logic [CNT_W-1:0] lim);
    if (!run || restart) begin
      next_count = '0;
    end else if (cnt < lim) begin
      next_count = cnt + 1'b1;
    end else begin
      next_count = cnt;
    end
  endfunction

  // True on the last fast cycle of a divide-by-2^code period
  function automatic logic div_hit(input logic [2:0] code, input logic [5:0] cnt);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (i < int'(code)) begin
        hit = hit & cnt[i];
      end
    end
    div_hit = hit;
  endfunction

  // ----------------------------------------------------------------------
  // Registers and internal state
  // ----------------------------------------------------------------------
  logic [2:0]       sysclk_select;
  logic             fast_source_select;
  logic             slow_source_select;
  logic             fast_keep_on_halt;
  logic             slow_keep_on_halt;
  logic [1:0]       fast_rc_freq_select;
  logic             fast_rc_enable;
  logic             fast_crystal_range;
  logic             fast_crystal_enable;
  logic             slow_crystal_speedup;
  logic             slow_crystal_enable;
  logic [CNT_W-1:0] rc_cnt;
  logic [CNT_W-1:0] hxt_cnt;
  logic [CNT_W-1:0] lxt_cnt;
  logic [2:0]       active_sel;
  logic [5:0]       fdiv;
  logic [8:0]       sdiv;
  logic             wr_mode;
  logic             wr_rc;
  logic             wr_hxt;
  logic             wr_lxt;
  logic [CNT_W-1:0] lxt_lim;
  logic             fast_rc_stable;
  logic             fast_crystal_stable;
  logic             slow_crystal_stable;
  logic             halted;
  logic             fast_ok;
  logic             slow_ok;
  logic             slow_hit;
  logic             raw_tick;
  logic             sys_run;
  logic             target_ok;
  scpm_osc_type     next_osc;

  // Write strobes per register
  assign wr_mode = reg_wr && (reg_addr == ADDR_MODE);
  assign wr_rc   = reg_wr && (reg_addr == ADDR_FAST_RC);
  assign wr_hxt  = reg_wr && (reg_addr == ADDR_FAST_XTAL);
  assign wr_lxt  = reg_wr && (reg_addr == ADDR_SLOW_XTAL);

  // Stable flags come from counters reaching the start-up time
  assign fast_rc_stable      = (rc_cnt == CNT_W'(FAST_RC_START_CYC));
  assign fast_crystal_stable = (hxt_cnt == CNT_W'(FAST_XTAL_START));
  assign slow_crystal_stable = (lxt_cnt == lxt_lim);
  assign lxt_lim = slow_crystal_speedup ? CNT_W'(SLOW_XT_FAST) : CNT_W'(SLOW_XT_LOWP);
  assign halted  = (op_mode != MODE_NORMAL) && (op_mode != MODE_SLOW);

  // ----------------------------------------------------------------------
  // Mode control register
  // ----------------------------------------------------------------------
  // Bit 4 has no storage, so writes to it vanish
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sysclk_select      <= MODE_RST[SEL_MSB:SEL_LSB];
      fast_source_select <= MODE_RST[FAST_SRC_BIT];
      slow_source_select <= MODE_RST[SLOW_SRC_BIT];
      fast_keep_on_halt  <= MODE_RST[FAST_KEEP_BIT];
      slow_keep_on_halt  <= MODE_RST[SLOW_KEEP_BIT];
    end else if (wr_mode) begin
      sysclk_select      <= reg_wdata[SEL_MSB:SEL_LSB];
      fast_source_select <= reg_wdata[FAST_SRC_BIT];   // [RULE2]
      slow_source_select <= reg_wdata[SLOW_SRC_BIT];   // [RULE3]
      fast_keep_on_halt  <= reg_wdata[FAST_KEEP_BIT];  // [RULE10]
      slow_keep_on_halt  <= reg_wdata[SLOW_KEEP_BIT];  // [RULE11]
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator control registers
  // ----------------------------------------------------------------------
  // Fast RC: enable resets to 1, upper nibble has no storage
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fast_rc_freq_select <= FAST_RC_RST[RC_FREQ_MSB:RC_FREQ_LSB];
      fast_rc_enable      <= FAST_RC_RST[ENABLE_BIT];  // [RULE16]
    end else if (wr_rc) begin
      fast_rc_freq_select <= reg_wdata[RC_FREQ_MSB:RC_FREQ_LSB];
      fast_rc_enable      <= reg_wdata[ENABLE_BIT];    // [RULE16] [RULE17]
    end
  end

  // Crystal range is frozen while the crystal is enabled; speed-up is frozen
  // once the slow crystal drives the system clock
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fast_crystal_range   <= FAST_XTAL_RST[XT_MODE_BIT];
      fast_crystal_enable  <= FAST_XTAL_RST[ENABLE_BIT];
      slow_crystal_speedup <= SLOW_XTAL_RST[XT_MODE_BIT];
      slow_crystal_enable  <= SLOW_XTAL_RST[ENABLE_BIT];
    end else begin
      if (wr_hxt) begin
        fast_crystal_enable <= reg_wdata[ENABLE_BIT];
        if (!fast_crystal_enable) begin
          fast_crystal_range <= reg_wdata[XT_MODE_BIT];
        end
      end
      if (wr_lxt) begin
        slow_crystal_enable <= reg_wdata[ENABLE_BIT];
        if (!(active_sel == SEL_SLOW && slow_source_select)) begin
          slow_crystal_speedup <= reg_wdata[XT_MODE_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator run requests
  // ----------------------------------------------------------------------
  // Selected fast source forced on only while a fast code is requested and
  // the CPU runs; otherwise the enable bits decide, gated by the keep bits
  always_comb begin
    next_osc = '0;
    next_osc.internal_fast_rc = (fast_rc_enable
        || (!halted && sysclk_select != SEL_SLOW && !fast_source_select))
        && (!halted || fast_keep_on_halt);                       // [RULE8] [RULE9] [RULE10]
    next_osc.external_fast_crystal = (fast_crystal_enable
        || (!halted && sysclk_select != SEL_SLOW && fast_source_select))
        && (!halted || fast_keep_on_halt);                       // [RULE9] [RULE10]
    next_osc.internal_slow_rc = (!slow_source_select
        && (!halted || slow_keep_on_halt)) || wdt_enable;         // [RULE11] [RULE12]
    next_osc.external_slow_crystal = (slow_crystal_enable
        || (!halted && sysclk_select == SEL_SLOW && slow_source_select))
        && (!halted || slow_keep_on_halt);                       // [RULE11]
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      osc_run <= '0;
    end else begin
      osc_run <= next_osc;
    end
  end

  // ----------------------------------------------------------------------
  // Start-up timers: stable flags fall on enable or frequency change
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rc_cnt  <= '0;
      hxt_cnt <= '0;
      lxt_cnt <= '0;
    end else begin
      rc_cnt  <= next_count(osc_run.internal_fast_rc,
                            wr_rc && ((reg_wdata[ENABLE_BIT] && !fast_rc_enable)
                            || reg_wdata[RC_FREQ_MSB:RC_FREQ_LSB] != fast_rc_freq_select),
                            rc_cnt, CNT_W'(FAST_RC_START_CYC));             // [RULE15]
      hxt_cnt <= next_count(osc_run.external_fast_crystal,
                            wr_hxt && reg_wdata[ENABLE_BIT] && !fast_crystal_enable,
                            hxt_cnt, CNT_W'(FAST_XTAL_START));              // [RULE18]
      lxt_cnt <= next_count(osc_run.external_slow_crystal,
                            wr_lxt && reg_wdata[ENABLE_BIT] && !slow_crystal_enable,
                            lxt_cnt, lxt_lim);                              // [RULE19]
    end
  end

  // Frequency applied only after the RC reports stable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fast_rc_freq_active <= FAST_RC_RST[RC_FREQ_MSB:RC_FREQ_LSB];
      fast_rc_mhz         <= 5'h08;
    end else if (fast_rc_stable) begin
      fast_rc_freq_active <= fast_rc_freq_select;                           // [RULE14]
      if (fast_rc_freq_select == RC_FREQ_12M) begin
        fast_rc_mhz <= 5'h0C;                                               // [RULE13]
      end else if (fast_rc_freq_select == RC_FREQ_16M) begin
        fast_rc_mhz <= 5'h10;
      end else begin
        fast_rc_mhz <= 5'h08;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock sources and dividers
  // ----------------------------------------------------------------------
  // The fast clock is represented by core_clk itself; slow by a divider
  assign fast_ok  = fast_source_select ? fast_crystal_stable
                                       : (fast_rc_stable && osc_run.internal_fast_rc); // [RULE2]
  assign slow_ok  = slow_source_select ? slow_crystal_stable
                                       : osc_run.internal_slow_rc;                    // [RULE3]
  assign slow_hit = (sdiv == 9'(SLOW_DIV_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fdiv <= '0;
      sdiv <= '0;
    end else begin
      if (fast_ok) begin
        fdiv <= fdiv + 6'h01;
      end
      if (!slow_ok || slow_hit) begin
        sdiv <= '0;
      end else begin
        sdiv <= sdiv + 9'h001;
      end
    end
  end

  // Tick of the clock now in use
  assign raw_tick = (active_sel == SEL_SLOW) ? (slow_ok && slow_hit)
                                             : (fast_ok && div_hit(active_sel, fdiv)); // [RULE1]
  assign target_ok = (sysclk_select == SEL_SLOW) ? slow_ok : fast_ok;

  // ----------------------------------------------------------------------
  // Glitch-free select: change at the end of a full period of the old clock, or at once
  // if the old source has stopped, and once the new source is stable; costs up to one old period
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      active_sel <= MODE_RST[SEL_MSB:SEL_LSB];
    end else if (active_sel != sysclk_select && target_ok
                 && (raw_tick || !((active_sel == SEL_SLOW) ? slow_ok : fast_ok))) begin
      active_sel <= sysclk_select;                                 // [RULE20] [RULE21] [RULE14]
    end
  end

  // ----------------------------------------------------------------------
  // Operating mode state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      op_mode <= MODE_NORMAL;
    end else begin
      case (op_mode)
        MODE_NORMAL, MODE_SLOW: begin
          if (halt_req) begin
            case ({fast_keep_on_halt, slow_keep_on_halt})
              2'b00: op_mode <= MODE_SLEEP;                         // [RULE4]
              2'b01: op_mode <= MODE_IDLE_SLOW_ONLY;                // [RULE5]
              2'b11: op_mode <= MODE_IDLE_BOTH_CLOCKS;              // [RULE6]
              default: op_mode <= MODE_IDLE_FAST_ONLY;              // [RULE7]
            endcase
          end else if (active_sel == SEL_SLOW) begin
            op_mode <= MODE_SLOW;
          end else begin
            op_mode <= MODE_NORMAL;                                 // [RULE8]
          end
        end
        default: begin
          if (wake_req) begin
            op_mode <= (active_sel == SEL_SLOW) ? MODE_SLOW : MODE_NORMAL;
          end
        end
      endcase
    end
  end

  // System clock gating per mode
  always_comb begin
    case (op_mode)
      MODE_SLEEP:            sys_run = 1'b0;                        // [RULE4]
      MODE_IDLE_SLOW_ONLY:   sys_run = (active_sel == SEL_SLOW);    // [RULE5]
      MODE_IDLE_BOTH_CLOCKS: sys_run = 1'b1;                        // [RULE6]
      MODE_IDLE_FAST_ONLY:   sys_run = (active_sel != SEL_SLOW);    // [RULE7]
      default:               sys_run = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sys_tick       <= 1'b0;
      cpu_run        <= 1'b0;
      fast_clock_run <= 1'b0;
      slow_clock_run <= 1'b0;
    end else begin
      sys_tick       <= raw_tick && sys_run;
      cpu_run        <= !halted;
      fast_clock_run <= fast_ok;
      slow_clock_run <= slow_ok && (!halted || slow_keep_on_halt);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rstn || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == ADDR_MODE) begin
      reg_rdata <= {sysclk_select, 1'b0, fast_source_select, slow_source_select,
                    fast_keep_on_halt, slow_keep_on_halt};                 // [RULE17]
    end else if (reg_addr == ADDR_FAST_RC) begin
      reg_rdata <= {4'h0, fast_rc_freq_select, fast_rc_stable, fast_rc_enable}; // [RULE17]
    end else if (reg_addr == ADDR_FAST_XTAL) begin
      reg_rdata <= {5'h00, fast_crystal_range, fast_crystal_stable, fast_crystal_enable};
    end else begin
      reg_rdata <= {5'h00, slow_crystal_speedup, slow_crystal_stable, slow_crystal_enable};
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence seq_halt(logic fk, logic sk);
    halt_req && !halted && fast_keep_on_halt == fk && slow_keep_on_halt == sk;
  endsequence

  sequence seq_cpu_off;
    !cpu_run ##1 !cpu_run;
  endsequence

  chk_sleep_entry: assert property (seq_halt(1'b0, 1'b0) |=> op_mode == MODE_SLEEP
      ##1 (seq_cpu_off and (!sys_tick)[*2])) // [RULE4]
    else $error("sleep entry wrong");
  chk_idle_slow: assert property (seq_halt(1'b0, 1'b1) |=> op_mode == MODE_IDLE_SLOW_ONLY
      ##1 (seq_cpu_off and (active_sel == SEL_SLOW || !sys_tick)[*2])) // [RULE5]
    else $error("slow-only idle entry wrong");
  chk_idle_both: assert property (seq_halt(1'b1, 1'b1) |=> op_mode == MODE_IDLE_BOTH_CLOCKS
      ##1 seq_cpu_off) // [RULE6]
    else $error("both-clock idle entry wrong");
  chk_idle_fast: assert property (seq_halt(1'b1, 1'b0) |=> op_mode == MODE_IDLE_FAST_ONLY
      ##1 (seq_cpu_off and (active_sel != SEL_SLOW || !sys_tick)[*2])) // [RULE7]
    else $error("fast-only idle entry wrong");
  chk_wdt_slow_rc: assert property (wdt_enable |=> osc_run.internal_slow_rc) // [RULE12]
    else $error("slow RC stopped with watchdog on");
  chk_rc_restart: assert property (wr_rc && reg_wdata[ENABLE_BIT] && !fast_rc_enable
      |=> !fast_rc_stable) // [RULE15]
    else $error("fast RC stable not cleared");
  chk_freq_hold: assert property (!fast_rc_stable |=> $stable(fast_rc_freq_active)) // [RULE14]
    else $error("frequency changed before stable");
  chk_slow_switch: assert property (active_sel != SEL_SLOW ##1 active_sel == SEL_SLOW
      |-> $past(slow_ok)) // [RULE20]
    else $error("switched to unstable slow clock");
  chk_div_two: assert property (sys_tick && $past(active_sel) == 3'h1 && active_sel == 3'h1
      |=> !sys_tick) // [RULE1]
    else $error("divide by two tick spacing wrong");
  chk_reserved_read: assert property (reg_rd && reg_addr == ADDR_FAST_RC
      |=> reg_rdata[7:4] == 4'h0) // [RULE17]
    else $error("reserved bits read nonzero");

endmodule
`default_nettype wire

// ===== verif/scpm_clock_ctrl_bench.sv
// Self-checking testbench for the system clock and power mode controller
`timescale 1ns/1ns
`default_nettype none
module scpm_clock_ctrl_bench
  import scpm_pkg::*;
;
  // ----------------------------------------------------------------------
  // Stimulus signals and design instance
  // ----------------------------------------------------------------------
  logic          core_clk, rstn, reg_wr, reg_rd, halt_req, wake_req, wdt_enable;
  logic [1:0]    reg_addr, fast_rc_freq_active;
  logic [7:0]    reg_wdata, reg_rdata, v;
  logic          cpu_run, sys_tick, fast_clock_run, slow_clock_run;
  logic [4:0]    fast_rc_mhz;
  scpm_osc_type  osc_run;
  scpm_mode_type op_mode;
  int            fail_count, checked;
  // Short crystal start-ups keep the run small
  scpm_clock_ctrl #(.FAST_XTAL_START(20), .SLOW_XT_FAST(30), .SLOW_XT_LOWP(60)) dut (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_req(halt_req),
    .wake_req(wake_req), .wdt_enable(wdt_enable), .cpu_run(cpu_run), .sys_tick(sys_tick),
    .fast_clock_run(fast_clock_run), .slow_clock_run(slow_clock_run), .osc_run(osc_run),
    .op_mode(op_mode), .fast_rc_freq_active(fast_rc_freq_active), .fast_rc_mhz(fast_rc_mhz));
  // ----------------------------------------------------------------------
  // Bus, compare and scenario tasks
  // ----------------------------------------------------------------------
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk); reg_wr <= 1'b0;
  endtask
  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge core_clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk); reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_rc;
    int i;
    for (i = 0; i < 200; i++) begin
      rd(ADDR_FAST_RC);
      if (v[STABLE_BIT] === 1'b1) break;
    end
    if (i == 200) begin
      fail_count++;
      conclude();
    end
  endtask
  // Counts ticks over a window that is a whole number of periods
  task automatic ticks(input int win, input int exp);
    int n;
    n = 0;
    repeat (win) begin
      @(posedge core_clk); #1 n += int'(sys_tick);
    end
    chk("ticks", 8'(exp), 8'(n));
  endtask
  task automatic t_regs;
    rd(ADDR_MODE); chk("mode rst", 8'h00, v);
    wait_rc(); chk("rc rst", 8'h03, v);
    wr(ADDR_MODE, 8'h10); rd(ADDR_MODE); chk("mode b4", 8'h00, v);
    wr(ADDR_FAST_RC, 8'hF1); rd(ADDR_FAST_RC); chk("rc hi", 8'h03, v);
    wr(ADDR_FAST_XTAL, 8'h01); rd(ADDR_FAST_XTAL); chk("fx new", 8'h01, v);
    repeat (40) @(posedge core_clk);
    rd(ADDR_FAST_XTAL); chk("fx ok", 8'h03, v);
    wr(ADDR_SLOW_XTAL, 8'h01); rd(ADDR_SLOW_XTAL); chk("sx new", 8'h01, v);
    repeat (80) @(posedge core_clk);
    rd(ADDR_SLOW_XTAL); chk("sx ok", 8'h03, v);
  endtask
  task automatic t_freq;
    logic [4:0] mhz [4];
    logic [4:0] old;
    mhz = '{5'h08, 5'h0C, 5'h10, 5'h08};
    old = 5'h08;
    for (int c = 1; c < 5; c++) begin
      wr(ADDR_FAST_RC, {4'h0, 2'(c), 2'b01}); rd(ADDR_FAST_RC);
      chk("rc clr", {4'h0, 2'(c), 2'b01}, v);
      chk("mhz old", {3'h0, old}, {3'h0, fast_rc_mhz});
      wait_rc(); old = mhz[c % 4];
      chk("mhz new", {3'h0, old}, {3'h0, fast_rc_mhz});
      chk("freq act", {6'h00, 2'(c)}, {6'h00, fast_rc_freq_active});
    end
  endtask
  task automatic t_div;
    for (int c = 0; c < 7; c++) begin
      wr(ADDR_MODE, {3'(c), 5'h00}); repeat (140) @(posedge core_clk);
      ticks(128, 128 >> c);
      chk("normal", {5'h00, MODE_NORMAL}, {5'h00, op_mode});
    end
    wr(ADDR_MODE, 8'hE0); repeat (400) @(posedge core_clk);
    chk("slow", {5'h00, MODE_SLOW}, {5'h00, op_mode});
    ticks(610, 2);
    wr(ADDR_MODE, 8'h00); repeat (400) @(posedge core_clk);
  endtask
  // Crystal sources with the fast RC switched off, then the RC restarted
  task automatic t_src;
    wr(ADDR_MODE, 8'h0C); wr(ADDR_FAST_RC, 8'h00); repeat (140) @(posedge core_clk);
    ticks(128, 128);
    chk("rc off", 8'h00, {7'h00, osc_run.internal_fast_rc});
    wr(ADDR_MODE, 8'hEC); repeat (400) @(posedge core_clk);
    ticks(610, 2);
    chk("slow osc", 8'h05, {4'h0, osc_run});
    wr(ADDR_FAST_RC, 8'h01); rd(ADDR_FAST_RC); chk("rc re-en", 8'h01, v);
    wait_rc(); wr(ADDR_MODE, 8'h00); repeat (400) @(posedge core_clk);
  endtask
  task automatic t_halt;
    scpm_mode_type m [4];
    m = '{MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_FAST_ONLY, MODE_IDLE_BOTH_CLOCKS};
    wdt_enable <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wait_rc(); wr(ADDR_MODE, 8'(k));
      @(posedge core_clk); halt_req <= 1'b1;
      @(posedge core_clk); halt_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk("halt mode", {5'h00, m[k]}, {5'h00, op_mode});
      chk("halt run", {6'h00, 2'(k)}, {6'h00, fast_clock_run, slow_clock_run});
      chk("cpu off", 8'h00, {7'h00, cpu_run});
      chk("wdt rc", 8'h01, {7'h00, osc_run.internal_slow_rc});
      chk("osc run", {4'h0, k[1], k[1], 1'b1, k[0]}, {4'h0, osc_run});
      @(posedge core_clk); wake_req <= 1'b1;
      @(posedge core_clk); wake_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk("cpu on", 8'h01, {7'h00, cpu_run});
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    {rstn, reg_wr, reg_rd, halt_req, wake_req, wdt_enable} = 6'h00;
    reg_addr = 2'h0; reg_wdata = 8'h00; fail_count = 0; checked = 0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs(); t_freq(); t_div(); t_src(); t_halt();
    conclude();
  end
endmodule
`default_nettype wire
